// ==== rtl/rtcd_tag.sv ====
/*
 * Tag end: qualifies each received command and decides execute, error
 * reply or silence, and which inventory data the tag returns.
 * Assumes frame, CRC and signature checks done upstream; sig_ok_in pulses
 * with cmd_valid when a standby-round signature matched.
 */
module rtcd_tag
    import rtcd_pkg::*;
#(
    parameter logic [39:0] OWN_SUID = 40'h00_0000_0001,
    // arbitrary maker code
    parameter logic [7:0] OWN_MFR = 8'h5a,
    parameter logic [63:0] SUPPORTED = 64'h0000_0000_0000_04fe,
    parameter logic [7:0] USER_PAGE_WORDS = 8'h01
)(
    input wire logic core_clk,
    input wire logic rst_b,
    rtcd_link_if.tag link,
    input wire logic sig_ok_in,
    input wire logic prop_lock_req,
    output rtcd_action_t action,
    output logic action_valid,
    output rtcd_data_t inv_data,
    output logic [8:0] round_slots,
    output logic [7:0] page_bits_div32,
    output logic selected,
    output logic prop_locked
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    rtcd_class_t cls;
    logic mand_rsvd;
    logic [8:0] slots;
    logic round_rsvd;

    rtcd_classify u_cls (
        .code(link.cmd_code),
        .round_code(link.cmd_param[ROUND_SIZE_MSB:0]),
        .cls(cls),
        .mand_rsvd(mand_rsvd),
        .slots(slots),
        .round_rsvd(round_rsvd)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rtcd_action_t action_reg, action_next;
    logic valid_reg, valid_next;
    rtcd_data_t inv_reg, inv_next;
    logic [8:0] slots_reg, slots_next;
    logic sel_reg, sel_next;
    logic lock_reg, lock_next;

    // ------------------------------------------------------------
    // qualify and next state
    // ------------------------------------------------------------
    logic suid_flag, round_init, inventory, match, supported, addressed, bad;

    always_comb begin
        suid_flag = link.cmd_param[SUID_FLAG_POS];
        round_init = link.cmd_code == CMD_INIT_ROUND || link.cmd_code == CMD_INIT_ROUND_ALL ||
                     link.cmd_code == CMD_BEGIN_ROUND || link.cmd_code == CMD_NEW_ROUND;
        inventory = round_init || link.cmd_code == CMD_NEXT_SLOT || link.cmd_code == CMD_CLOSE_SLOT;
        // a foreign identifier leaves the command unaddressed
        // relies on identifier present with flag
        match = suid_flag && link.suid_present && link.cmd_suid == OWN_SUID;
        supported = SUPPORTED[link.cmd_code];
        if (cls == RTCD_CLASS_CUST && link.cmd_mfr != OWN_MFR) begin
            supported = 1'b0;
        end
        if (cls == RTCD_CLASS_PROP && lock_reg) begin
            supported = 1'b0;
        end
        // a reserved round size also keeps the old slot count
        // reserved codes count as unsupported
        bad = mand_rsvd || (round_init && round_rsvd);
        if (bad) begin
            supported = 1'b0;
        end
        addressed = suid_flag ? match : sel_reg;

        action_next = RTCD_ACT_IGNORE;
        valid_next = 1'b0;
        inv_next = inv_reg;
        slots_next = slots_reg;
        sel_next = sel_reg;
        // sticky until reset; nothing in field use clears it
        lock_next = lock_reg | prop_lock_req;

        if (link.cmd_valid) begin
            valid_next = 1'b1;
            if (inventory && !bad) begin
                action_next = RTCD_ACT_EXECUTE;
                if (round_init) begin
                    inv_next = suid_flag ? RTCD_DATA_SUID : RTCD_DATA_PAGE;
                    slots_next = slots;
                end
            end else if (link.cmd_code == CMD_STANDBY_ROUND) begin
                action_next = RTCD_ACT_EXECUTE;
                // standby answers even unselected; only the signature selects
                // signed standby selects
                if (sig_ok_in) begin
                    sel_next = 1'b1;
                end
            end else if (link.cmd_code == CMD_RESET_READY) begin
                action_next = RTCD_ACT_EXECUTE;
                sel_next = 1'b0;
            end else if (!addressed) begin
                action_next = RTCD_ACT_IGNORE;
            end else if (supported) begin
                // flags read the same for custom
                action_next = RTCD_ACT_EXECUTE;
                if (link.cmd_code == CMD_SELECT) begin
                    sel_next = 1'b1;
                end
            end else begin
                action_next = RTCD_ACT_ERROR;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            action_reg <= RTCD_ACT_IGNORE;
            valid_reg <= 1'b0;
            inv_reg <= RTCD_DATA_NONE;
            slots_reg <= SLOTS_RST;
            sel_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            action_reg <= action_next;
            valid_reg <= valid_next;
            inv_reg <= inv_next;
            slots_reg <= slots_next;
            sel_reg <= sel_next;
            lock_reg <= lock_next;
        end
    end

    // ------------------------------------------------------------
    // user page length
    // ------------------------------------------------------------
    // whole words only, so an empty page is simply zero words
    logic [7:0] page_reg, page_next;
    always_comb begin
        page_next = USER_PAGE_WORDS;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            page_reg <= 8'h00;
        end else begin
            page_reg <= page_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is a register, so no decode glitch reaches the far end
    assign action = action_reg;
    assign action_valid = valid_reg;
    assign inv_data = inv_reg;
    assign round_slots = slots_reg;
    assign page_bits_div32 = page_reg;
    assign selected = sel_reg;
    assign prop_locked = lock_reg;
    assign link.sig_valid = valid_reg;

endmodule

// ==== rtl/rtcd_pkg.sv ====
/*
 * Shared constants and types for the tag command qualifier and the
 * interrogator-side command issuer.
 * Assumes one clock (core_clk) and a synchronous active-low reset.
 */
package rtcd_pkg;

    // ------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------
    localparam int CODE_W = 6;
    localparam int PARAM_W = 4;
    localparam int SUID_W = 40;
    localparam int MFR_W = 8;
    localparam int SLOTS_W = 9;
    localparam int PAGE_W = 8;

    // ------------------------------------------------------------
    // field positions inside the 4-bit parameter field
    // ------------------------------------------------------------
    localparam int SUID_FLAG_POS = 3;
    localparam int ROUND_SIZE_MSB = 2;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [5:0] CMD_RSVD_00 = 6'h00;
    localparam logic [5:0] CMD_INIT_ROUND = 6'h01;
    localparam logic [5:0] CMD_NEXT_SLOT = 6'h02;
    localparam logic [5:0] CMD_CLOSE_SLOT = 6'h03;
    localparam logic [5:0] CMD_STANDBY_ROUND = 6'h04;
    localparam logic [5:0] CMD_NEW_ROUND = 6'h05;
    localparam logic [5:0] CMD_RESET_READY = 6'h06;
    localparam logic [5:0] CMD_SELECT = 6'h07;
    localparam logic [5:0] CMD_INIT_ROUND_ALL = 6'h0a;
    localparam logic [5:0] CMD_BEGIN_ROUND = 6'h0b;
    localparam logic [5:0] CMD_MAND_RSVD_LO = 6'h0c;
    localparam logic [5:0] CMD_MAND_RSVD_HI = 6'h0f;
    localparam logic [5:0] CMD_OPT_LO = 6'h10;
    localparam logic [5:0] CMD_OPT_HI = 6'h27;
    localparam logic [5:0] CMD_CUST_LO = 6'h28;
    localparam logic [5:0] CMD_CUST_HI = 6'h37;
    localparam logic [5:0] CMD_PROP_LO = 6'h38;

    localparam logic [2:0] ROUND_SIZE_RSVD = 3'h7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [8:0] SLOTS_RST = 9'h001;

    typedef enum logic [1:0] {
        RTCD_CLASS_MAND = 2'b00,
        RTCD_CLASS_OPT = 2'b01,
        RTCD_CLASS_CUST = 2'b10,
        RTCD_CLASS_PROP = 2'b11
    } rtcd_class_t;

    typedef enum logic [1:0] {
        RTCD_ACT_IGNORE = 2'b00,
        RTCD_ACT_EXECUTE = 2'b01,
        RTCD_ACT_ERROR = 2'b10
    } rtcd_action_t;

    typedef enum logic [1:0] {
        RTCD_DATA_NONE = 2'b00,
        RTCD_DATA_PAGE = 2'b01,
        RTCD_DATA_SUID = 2'b10
    } rtcd_data_t;

endpackage

// ==== rtl/rtcd_link_if.sv ====
/*
 * Command link between interrogator end and tag end.
 * Assumes both ends share core_clk; one decoded command per valid pulse.
 */
interface rtcd_link_if;
    import rtcd_pkg::*;

    logic cmd_valid;
    logic [5:0] cmd_code;
    logic [3:0] cmd_param;
    logic suid_present;
    logic [39:0] cmd_suid;
    logic [7:0] cmd_mfr;
    logic sig_valid;

    modport interrogator (
        output cmd_valid, cmd_code, cmd_param, suid_present, cmd_suid, cmd_mfr
    );
    modport tag (
        input cmd_valid, cmd_code, cmd_param, suid_present, cmd_suid, cmd_mfr,
        output sig_valid
    );
endinterface

// ==== rtl/rtcd_classify.sv ====
/*
 * Pure decode of command code class and round size.
 * Assumes nothing beyond the package; combinational only.
 */
module rtcd_classify
    import rtcd_pkg::*;
(
    input wire logic [5:0] code,
    input wire logic [2:0] round_code,
    output rtcd_class_t cls,
    output logic mand_rsvd,
    output logic [8:0] slots,
    output logic round_rsvd
);

    always_comb begin
        mand_rsvd = 1'b0;
        if (code == CMD_RSVD_00 || (code >= CMD_MAND_RSVD_LO && code <= CMD_MAND_RSVD_HI)) begin
            cls = RTCD_CLASS_MAND;
            mand_rsvd = 1'b1;
        end else if (code == CMD_NEXT_SLOT || code == CMD_STANDBY_ROUND ||
                     code == CMD_RESET_READY || code == CMD_INIT_ROUND_ALL) begin
            cls = RTCD_CLASS_MAND;
        end else if (code >= CMD_PROP_LO) begin
            cls = RTCD_CLASS_PROP;
        end else if (code >= CMD_CUST_LO && code <= CMD_CUST_HI) begin
            cls = RTCD_CLASS_CUST;
        end else begin
            cls = RTCD_CLASS_OPT;
        end
    end

    always_comb begin
        round_rsvd = 1'b0;
        case (round_code)
            3'h0: slots = 9'h001;
            3'h1: slots = 9'h008;
            3'h2: slots = 9'h010;
            3'h3: slots = 9'h020;
            3'h4: slots = 9'h040;
            3'h5: slots = 9'h080;
            3'h6: slots = 9'h100;
            default: begin
                slots = 9'h000;
                round_rsvd = 1'b1;
            end
        endcase
    end

endmodule

// ==== rtl/rtcd_reader.sv ====
/*
 * Interrogator end: registers a user command onto the link and attaches
 * the serial identifier only when the identifier flag is set.
 * Assumes user holds fields stable while req is high for one cycle.
 */
module rtcd_reader
    import rtcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic req,
    input wire logic [5:0] code,
    input wire logic [3:0] param,
    input wire logic [39:0] suid,
    input wire logic [7:0] mfr,
    rtcd_link_if.interrogator link,
    output logic busy
);

    logic valid_reg, valid_next;
    logic [5:0] code_reg, code_next;
    logic [3:0] param_reg, param_next;
    logic pres_reg, pres_next;
    logic [39:0] suid_reg, suid_next;
    logic [7:0] mfr_reg, mfr_next;

    always_comb begin
        valid_next = req;
        code_next = code_reg;
        param_next = param_reg;
        pres_next = pres_reg;
        suid_next = suid_reg;
        mfr_next = mfr_reg;
        if (req) begin
            code_next = code;
            param_next = param;
            pres_next = param[SUID_FLAG_POS];
            suid_next = param[SUID_FLAG_POS] ? suid : 40'h00_0000_0000;
            mfr_next = mfr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            valid_reg <= 1'b0;
            code_reg <= 6'h00;
            param_reg <= 4'h0;
            pres_reg <= 1'b0;
            suid_reg <= 40'h00_0000_0000;
            mfr_reg <= 8'h00;
        end else begin
            valid_reg <= valid_next;
            code_reg <= code_next;
            param_reg <= param_next;
            pres_reg <= pres_next;
            suid_reg <= suid_next;
            mfr_reg <= mfr_next;
        end
    end

    assign link.cmd_valid = valid_reg;
    assign link.cmd_code = code_reg;
    assign link.cmd_param = param_reg;
    assign link.suid_present = pres_reg;
    assign link.cmd_suid = suid_reg;
    assign link.cmd_mfr = mfr_reg;
    assign busy = valid_reg;

endmodule

// ==== tb/rtcd_checker.sv ====
/*
 * Link checker between the interrogator end and the tag end.
 * Assumes it is instantiated beside the link interface, one clock domain.
 */
module rtcd_checker
    import rtcd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [5:0] cmd_code,
    input wire logic [3:0] cmd_param,
    input wire logic suid_present,
    input wire logic [39:0] cmd_suid,
    input wire logic [7:0] cmd_mfr,
    input wire logic sig_valid
);
    // ------------------------------------------------------------
    // link properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sig_after_cmd_a: assert property (cmd_valid |=> sig_valid)
        else $error("tag gave no answer one cycle after a command");
    sig_quiet_a: assert property (!cmd_valid |=> !sig_valid)
        else $error("tag answered with no command before it");
    sig_cause_a: assert property (sig_valid |-> $past(cmd_valid))
        else $error("answer strobe without a preceding command");
    flag_present_a: assert property (cmd_valid |-> suid_present == cmd_param[SUID_FLAG_POS])
        else $error("identifier presence differs from parameter msb");
    suid_omit_a: assert property (cmd_valid && !cmd_param[3] |-> cmd_suid == 40'h0)
        else $error("identifier carried with flag clear");
    suid_flag_a: assert property (cmd_valid && cmd_param[3] |-> suid_present)
        else $error("flagged command sent without identifier");
    cmd_cover: cover property (cmd_valid && cmd_param[3]);
endmodule

// ==== tb/tb_top.sv ====
/*
 * Bench joining the interrogator end and the tag end through the link.
 * Assumes tag identifier 1, maker 5a, and a support map adding codes 28 and 3f.
 */
module tb_top
    import rtcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_b, req, sig_ok_in, prop_lock_req;
    logic [5:0] code;
    logic [3:0] param;
    logic [39:0] suid;
    logic [7:0] mfr;
    rtcd_action_t action;
    rtcd_data_t inv_data;
    logic action_valid, selected, prop_locked, busy;
    logic [8:0] round_slots;
    logic [7:0] page_bits_div32;
    int bad_count, n_tests, k, r, f, i;
    logic [5:0] rc [4] = '{6'h01, 6'h0a, 6'h0b, 6'h05};
    logic [5:0] mr [5] = '{6'h00, 6'h0c, 6'h0d, 6'h0e, 6'h0f};

    rtcd_link_if link();
    rtcd_reader u_rtcd_reader(.core_clk(core_clk), .rst_b(rst_b), .req(req), .code(code), .param(param),
        .suid(suid), .mfr(mfr), .link(link), .busy(busy));
    rtcd_tag #(.SUPPORTED(64'h8000_0100_0000_04fe)) u_rtcd_tag(.core_clk(core_clk), .rst_b(rst_b), .link(link),
        .sig_ok_in(sig_ok_in),
        .prop_lock_req(prop_lock_req), .action(action), .action_valid(action_valid), .inv_data(inv_data),
        .round_slots(round_slots), .page_bits_div32(page_bits_div32), .selected(selected),
        .prop_locked(prop_locked));
    rtcd_checker u_rtcd_checker(.core_clk(core_clk), .rst_b(rst_b), .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .cmd_param(link.cmd_param), .suid_present(link.suid_present),
        .cmd_suid(link.cmd_suid), .cmd_mfr(link.cmd_mfr), .sig_valid(link.sig_valid));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // called at a falling edge; returns at the falling edge after the answer
    task automatic cmd(input logic [5:0] c, input logic [3:0] p, input logic [39:0] s, input rtcd_action_t e);
        int n;
        code = c;
        param = p;
        suid = s;
        req = 1'b1;
        @(negedge core_clk);
        req = 1'b0;
        chk({8'h00, busy}, 9'h001);
        for (n = 0; n < 8 && action_valid !== 1'b1; n++) @(negedge core_clk);
        if (n == 8) begin
            bad_count++;
            complete_run();
        end else begin
            chk(9'(action), 9'(e));
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        {rst_b, req, sig_ok_in, prop_lock_req, code, param, suid} = '0;
        mfr = 8'h5a;
        repeat (6) @(negedge core_clk);
        rst_b = 1'b1;
        chk(round_slots, 9'h001);
        chk({8'h00, selected}, 9'h000);
        chk({prop_locked, action_valid}, 9'h000);
        chk({8'h00, busy}, 9'h000);
        $display("test reset done");
        // every round-init code, size and flag
        for (k = 0; k < 4; k++) for (r = 0; r < 8; r++) for (f = 0; f < 2; f++) begin
            cmd(rc[k], {f[0], r[2:0]}, 40'h1, r == 7 ? (f ? RTCD_ACT_ERROR : RTCD_ACT_IGNORE) : RTCD_ACT_EXECUTE);
            if (r < 7) begin
                chk(9'(inv_data), f ? 9'(RTCD_DATA_SUID) : 9'(RTCD_DATA_PAGE));
                chk(round_slots, r == 0 ? 9'h001 : 9'h001 << (r + 2));
                chk(9'(page_bits_div32), 9'h001);
            end else begin
                chk(round_slots, 9'h100);
            end
        end
        $display("test rounds done");
        for (i = 0; i < 5; i++) cmd(mr[i], 4'h0, 40'h0, RTCD_ACT_IGNORE);
        cmd(6'h08, 4'h0, 40'h0, RTCD_ACT_IGNORE);
        cmd(6'h28, 4'h0, 40'h0, RTCD_ACT_IGNORE);
        cmd(6'h38, 4'h0, 40'h0, RTCD_ACT_IGNORE);
        cmd(6'h08, 4'h8, 40'h2, RTCD_ACT_IGNORE);
        cmd(6'h08, 4'h8, 40'h1, RTCD_ACT_ERROR);
        cmd(6'h29, 4'h8, 40'h1, RTCD_ACT_ERROR);
        cmd(6'h07, 4'h8, 40'h2, RTCD_ACT_IGNORE);
        chk({8'h00, selected}, 9'h000);
        cmd(6'h07, 4'h8, 40'h1, RTCD_ACT_EXECUTE);
        chk({8'h00, selected}, 9'h001);
        $display("test addressing done");
        for (i = 0; i < 5; i++) cmd(mr[i], 4'h0, 40'h0, RTCD_ACT_ERROR);
        cmd(6'h08, 4'h0, 40'h0, RTCD_ACT_ERROR);
        cmd(6'h09, 4'h0, 40'h0, RTCD_ACT_ERROR);
        cmd(6'h29, 4'h0, 40'h0, RTCD_ACT_ERROR);
        cmd(6'h28, 4'h0, 40'h0, RTCD_ACT_EXECUTE);
        mfr = 8'h11;
        cmd(6'h28, 4'h0, 40'h0, RTCD_ACT_ERROR);
        cmd(6'h37, 4'h0, 40'h0, RTCD_ACT_ERROR);
        mfr = 8'h5a;
        cmd(6'h38, 4'h0, 40'h0, RTCD_ACT_ERROR);
        cmd(6'h03, 4'h0, 40'h0, RTCD_ACT_EXECUTE);
        cmd(6'h02, 4'h0, 40'h0, RTCD_ACT_EXECUTE);
        cmd(6'h06, 4'h0, 40'h0, RTCD_ACT_EXECUTE);
        chk({8'h00, selected}, 9'h000);
        cmd(6'h08, 4'h0, 40'h0, RTCD_ACT_IGNORE);
        $display("test selected done");
        cmd(6'h04, 4'h0, 40'h0, RTCD_ACT_EXECUTE);
        chk({8'h00, selected}, 9'h000);
        sig_ok_in = 1'b1;
        cmd(6'h04, 4'h0, 40'h0, RTCD_ACT_EXECUTE);
        chk({8'h00, selected}, 9'h001);
        sig_ok_in = 1'b0;
        cmd(6'h3f, 4'h0, 40'h0, RTCD_ACT_EXECUTE);
        prop_lock_req = 1'b1;
        repeat (2) @(negedge core_clk);
        prop_lock_req = 1'b0;
        cmd(6'h3f, 4'h0, 40'h0, RTCD_ACT_ERROR);
        chk({8'h00, prop_locked}, 9'h001);
        $display("test standby and lock done");
        // second reset clears selection and size
        rst_b = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        chk({8'h00, selected}, 9'h000);
        chk(round_slots, 9'h001);
        cmd(6'h08, 4'h0, 40'h0, RTCD_ACT_IGNORE);
        $display("test second reset done");
        complete_run();
    end
endmodule
